// *** dv/dlt_host_model.sv ***
// host controller model: query and ddr read frames on the link
`timescale 1ns/1ps
module dlt_host_model
(
   input  wire logic       clk,
   input  wire logic [3:0] io_wire,
   input  wire logic [3:0] dev_oe,
   output logic            sck,
   output logic            cs_n,
   output logic      [3:0] io_drv,
   output logic      [7:0] res_val,
   output logic            res_byte_v,
   output logic            res_lat_v
);
   // idle: link clock parked low, nothing selected
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      io_drv = 4'h5;
      res_val = 8'h00;
      res_byte_v = 1'b0;
      res_lat_v = 1'b0;
   end

   // slow link clock
   // 40 ns half period stays inside every supported row
   task automatic half();
      repeat (10) @(negedge clk);
   endtask

   task automatic sdr_bit(input logic b);
      io_drv[0] = b;
      half();
      sck = 1'b1;
      half();
      sck = 1'b0;
   endtask

   task automatic ddr_edge(input logic [3:0] v);
      io_drv = v;
      half();
      sck = ~sck;
      repeat (2) @(negedge clk); // data held past the edge
   endtask

   task automatic pulse(input logic [7:0] v, input logic lat);
      res_val = v;
      res_lat_v = lat;
      res_byte_v = !lat;
      @(negedge clk);
      res_lat_v = 1'b0;
      res_byte_v = 1'b0;
   endtask

   // released lanes show the inverse, never a stale copy
   task automatic frame_end();
      sck = 1'b0;
      half();
      cs_n = 1'b1;
      io_drv = ~io_drv;
      half();
   endtask

   // one table bit per fall on io1, msb first
   task automatic query(input logic [7:0] a, input int nb);
      logic [31:0] cmd;
      logic [7:0]  b;
      cmd = {dlt_pkg::DLT_OP_QUERY, 16'h0000, a};
      b = 8'h00;
      cs_n = 1'b0;
      for (int i = 31; i >= 0; i--)
         sdr_bit(cmd[i]);
      io_drv = ~io_drv;
      for (int m = 0; m < nb * 8; m++)
      begin
         if (m > 0)
         begin
            sck = 1'b1;
            half();
            sck = 1'b0;
         end
         half();
         b = {b[6:0], io_wire[1]};
         if (m % 8 == 7)
            pulse(b, 1'b0);
      end
      frame_end();
   endtask

   task automatic ddr_read(input logic [7:0] op, input logic [31:0] a,
                           input int abits, input int w, input int nb);
      logic [7:0] b;
      int         n;
      b = 8'h00;
      n = 0;
      cs_n = 1'b0;
      for (int i = 7; i >= 0; i--)
         sdr_bit(op[i]);
      for (int i = abits - w; i >= 0; i -= w)
         ddr_edge(4'(a >> i));
      if (w == 4)
      begin
         ddr_edge(4'h0);
         ddr_edge(4'h0);
      end
      io_drv = ~io_drv;
      // falls counted until the device turns the lanes round
      do
      begin
         half();
         sck = 1'b1;
         half();
         sck = 1'b0;
         n++;
         half();
      end
      while (dev_oe == 4'h0 && n < 12);
      pulse(8'(n), 1'b1);
      for (int m = 0; m < nb * 8 / w; m++)
      begin
         if (m > 0)
         begin
            sck = ~sck;
            half();
         end
         b = (w == 1) ? {b[6:0], io_wire[1]} :
             (w == 2) ? {b[5:0], io_wire[1:0]} : {b[3:0], io_wire};
         if ((m + 1) % (8 / w) == 0)
            pulse(b, 1'b0);
      end
      frame_end();
   endtask
endmodule // dlt_host_model

// *** dv/dlt_top_asserts.sv ***
// checker on the ports of the ddr read latency table top
`timescale 1ns/1ps
module dlt_top_asserts
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        sck,
   input wire logic        cs_n,
   input wire logic [3:0]  io_in,
   input wire logic [3:0]  io_out,
   input wire logic [3:0]  io_oe,
   input wire logic [1:0]  latency_code,
   input wire logic [31:0] mem_addr,
   input wire logic [7:0]  mem_rd_data,
   input wire logic        mem_rd
);
   logic       sck_reg;
   logic [5:0] rise_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // raw link clock one clk late, for rise detection
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         sck_reg <= 1'b0;
      else
         sck_reg <= sck;
   end

   // rises since select; saturates so long frames cannot wrap
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         rise_reg <= 6'h00;
      else if (cs_n)
         rise_reg <= 6'h00;
      else if (sck && !sck_reg && rise_reg != 6'h3F)
         rise_reg <= rise_reg + 6'h01;
   end

   sequence sel_idle;
      cs_n [*8];
   endsequence
   sequence data_run;
      (io_oe != 4'h0 && !cs_n) ##1 (io_oe != 4'h0 && !cs_n);
   endsequence

   lanes_legal_a:
      assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
      else $error("output enable outside the lane patterns");
   opcode_quiet_a:
      assert property ((!cs_n && rise_reg < 6'h08) |-> io_oe == 4'h0)
      else $error("lanes driven during the opcode");
   early_data_a:
      assert property ($rose(io_oe != 4'h0) |-> rise_reg >= 6'h0F)
      else $error("data driven before the shortest latency");
   lanes_release_a:
      assert property (sel_idle |-> io_oe == 4'h0)
      else $error("lanes still driven while deselected");
   rd_pulse_a:
      assert property (mem_rd |=> !mem_rd)
      else $error("memory read longer than one clk");
   rd_driving_a:
      assert property (mem_rd |-> ##[0:4] (io_oe != 4'h0))
      else $error("memory read without a data phase");
   addr_step_a:
      assert property (data_run ##0 $changed(mem_addr)
                       |-> mem_addr == $past(mem_addr) + 32'h1)
      else $error("read address did not step by one");
   out_step_a:
      assert property ((!cs_n && $changed(io_out))
                       |-> $past(sck, 2) != $past(sck, 5))
      else $error("output changed away from a link edge");
endmodule // dlt_top_asserts

bind dlt_top dlt_top_asserts u_dlt_top_asserts
(
   .clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .io_in(io_in),
   .io_out(io_out), .io_oe(io_oe), .latency_code(latency_code),
   .mem_addr(mem_addr), .mem_rd_data(mem_rd_data), .mem_rd(mem_rd)
);

// *** dv/tb_ddr_read_latency_table.sv ***
// testbench: table query reads and ddr reads at every latency code
`timescale 1ns/1ps
module tb_ddr_read_latency_table;
   localparam logic [7:0] DDR_IMG [45] = '{
      8'h9A, 8'h2A, 8'h05, 8'h08, 8'h46, 8'h43, 8'h0D, 8'h0E, 8'hBD,
      8'hBE, 8'hED, 8'hEE, 8'h32, 8'h03, 8'h00, 8'h04, 8'h00, 8'h04,
      8'h01, 8'h03, 8'h42, 8'h00, 8'h00, 8'h05, 8'h00, 8'h06, 8'h01,
      8'h06, 8'h42, 8'h01, 8'h00, 8'h06, 8'h00, 8'h07, 8'h01, 8'h07,
      8'h42, 8'h02, 8'h00, 8'h07, 8'h00, 8'h08, 8'h01, 8'h08, 8'hFF};
   localparam logic [7:0] SDR_IMG [15] = '{8'h85, 8'h02, 8'hFF, 8'hFF,
      8'h00, 8'h08, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'hFF};
   // fast, dual, quad latency for codes 00b to 11b
   localparam logic [7:0] LAT [12] = '{8'h05, 8'h06, 8'h06, 8'h06,
      8'h07, 8'h07, 8'h07, 8'h08, 8'h08, 8'h04, 8'h04, 8'h03};
   localparam logic [7:0] OPS [6] = '{8'h0D, 8'h0E, 8'hBD, 8'hBE,
      8'hED, 8'hEE};
   logic        clk;
   logic        resetn;
   logic        sck;
   logic        cs_n;
   logic [3:0]  io_drv;
   logic [3:0]  io_wire;
   logic [3:0]  io_out;
   logic [3:0]  io_oe;
   logic [1:0]  latency_code;
   logic [31:0] mem_addr;
   logic [7:0]  mem_rd_data;
   logic        mem_rd;
   logic [7:0]  res_val;
   logic        res_byte_v;
   logic        res_lat_v;
   logic [31:0] addr;
   logic [7:0]  exp_byte [$];
   logic [7:0]  exp_lat [$];
   int          errors;
   int          checks;

   function automatic logic [7:0] mem_byte(input logic [31:0] a);
      return a[7:0] ^ a[31:24] ^ 8'h3C;
   endfunction

   // array stand-in answers at once; host drives every lane the device enable leaves free
   assign mem_rd_data = mem_byte(mem_addr);
   assign io_wire = (io_oe & io_out) | (~io_oe & io_drv);

   dlt_top u_dlt_top
   (
      .clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n),
      .io_in(io_wire), .io_out(io_out), .io_oe(io_oe),
      .latency_code(latency_code), .mem_addr(mem_addr),
      .mem_rd_data(mem_rd_data), .mem_rd(mem_rd)
   );

   dlt_host_model u_dlt_host_model
   (
      .clk(clk), .io_wire(io_wire), .dev_oe(io_oe), .sck(sck),
      .cs_n(cs_n), .io_drv(io_drv), .res_val(res_val),
      .res_byte_v(res_byte_v), .res_lat_v(res_lat_v)
   );

   initial clk = 1'b0;
   always #2 clk = ~clk;

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic show(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got,
                  exp);
      end
   endtask

   task automatic compare_byte(input logic [7:0] got,
                               input logic [7:0] exp);
      show(got, exp);
   endtask

   task automatic compare_lat(input logic [7:0] got,
                              input logic [7:0] exp);
      show(got, exp);
   endtask

   // oldest note taken off whenever the host reports a result
   always @(posedge clk)
   begin
      if (res_lat_v && exp_lat.size() > 0)
         compare_lat(res_val, exp_lat.pop_front()); // falls
      if (res_byte_v && exp_byte.size() > 0)
         compare_byte(res_val, exp_byte.pop_front()); // data
   end

   // hang guard
   initial
   begin
      for (int i = 0; i < 100000; i++)
         @(posedge clk);
      errors++;
      close_out();
   end

   initial
   begin
      resetn = 1'b0;
      latency_code = 2'b11;
      errors = 0;
      checks = 0;
      addr = 32'h0;
      void'($urandom(32'h808C));
      repeat (12) @(posedge clk);
      @(negedge clk);
      resetn = 1'b1;
      repeat (8) @(negedge clk);
      // whole parameter up to the next one, by its length byte
      for (int i = 0; i < int'(8'h2A) + 3; i++)
         exp_byte.push_back(DDR_IMG[i]); // bytes
      u_dlt_host_model.query(8'h00, int'(8'h2A) + 3);
      $display("query of the ddr parameter finished");
      for (int i = 0; i < 15; i++)
         exp_byte.push_back(SDR_IMG[i]); // unsupported
      u_dlt_host_model.query(8'h80, 15);
      $display("query of the fastest sdr row finished");
      for (int c = 0; c < 4; c++)
      begin
         for (int k = 0; k < 6; k++)
         begin
            @(negedge clk);
            latency_code = 2'(c);
            addr = $urandom();
            if (k % 2 == 0)
               addr[31:24] = 8'h00;
            exp_lat.push_back(LAT[c * 3 + k / 2]); // per code
            exp_byte.push_back(mem_byte(addr));
            exp_byte.push_back(mem_byte(addr + 32'h1));
            u_dlt_host_model.ddr_read(OPS[k], addr, 24 + 8 * (k % 2),
                                      1 << (k / 2), 2);
         end
         $display("ddr reads with latency code %0d finished", c);
      end
      for (int i = 0; i < 200 && exp_lat.size() + exp_byte.size() > 0; i++)
         @(posedge clk);
      if (exp_lat.size() + exp_byte.size() > 0)
         errors++;
      close_out();
   end
endmodule // tb_ddr_read_latency_table

// *** rtl/dlt_pkg.sv ***
// constants and types for the ddr read latency query table
package dlt_pkg;

   // parameter header bytes
   localparam logic [7:0] DLT_PARAM_ID   = 8'h9A;
   localparam logic [7:0] DLT_PARAM_LEN  = 8'h2A;
   localparam logic [7:0] DLT_NUM_ROWS   = 8'h05;
   localparam logic [7:0] DLT_ROW_LEN    = 8'h08;
   localparam logic [7:0] DLT_ASCII_F    = 8'h46;
   localparam logic [7:0] DLT_ASCII_C    = 8'h43;

   // ddr read opcodes, three and four byte address forms
   localparam logic [7:0] DLT_OP_FAST3   = 8'h0D;
   localparam logic [7:0] DLT_OP_FAST4   = 8'h0E;
   localparam logic [7:0] DLT_OP_DUAL3   = 8'hBD;
   localparam logic [7:0] DLT_OP_DUAL4   = 8'hBE;
   localparam logic [7:0] DLT_OP_QUAD3   = 8'hED;
   localparam logic [7:0] DLT_OP_QUAD4   = 8'hEE;
   // opcode that reads the query table, single line, 3 address bytes
   localparam logic [7:0] DLT_OP_QUERY   = 8'h5A;

   // all-ones entry: command not supported at that frequency
   localparam logic [7:0] DLT_NOT_SUPP   = 8'hFF;

   // ddr parameter image, offsets 00h to 2Bh
   localparam int DLT_DDR_SIZE = 44;
   localparam logic [7:0] DLT_DDR_ROM [DLT_DDR_SIZE] = '{
      DLT_PARAM_ID, DLT_PARAM_LEN, DLT_NUM_ROWS, DLT_ROW_LEN,
      DLT_ASCII_F, DLT_ASCII_C,
      DLT_OP_FAST3, DLT_OP_FAST4, DLT_OP_DUAL3, DLT_OP_DUAL4,
      DLT_OP_QUAD3, DLT_OP_QUAD4,
      8'h32, 8'h03, 8'h00, 8'h04, 8'h00, 8'h04, 8'h01, 8'h03,
      8'h42, 8'h00, 8'h00, 8'h05, 8'h00, 8'h06, 8'h01, 8'h06,
      8'h42, 8'h01, 8'h00, 8'h06, 8'h00, 8'h07, 8'h01, 8'h07,
      8'h42, 8'h02, 8'h00, 8'h07, 8'h00, 8'h08, 8'h01, 8'h08};

   // last single-data-rate row (up to 133 MHz), offsets 4Ah to 57h
   localparam int DLT_SDR_SIZE = 14;
   localparam logic [7:0] DLT_SDR_ROM [DLT_SDR_SIZE] = '{
      8'h85, 8'h02, DLT_NOT_SUPP, DLT_NOT_SUPP, 8'h00, 8'h08,
      DLT_NOT_SUPP, DLT_NOT_SUPP, DLT_NOT_SUPP, DLT_NOT_SUPP,
      DLT_NOT_SUPP, DLT_NOT_SUPP, DLT_NOT_SUPP, DLT_NOT_SUPP};
   // query address where the sdr row tail is mapped
   localparam int DLT_SDR_BASE = 128;

   // layout of the latency rows
   localparam int DLT_ROW_BASE = 12;
   localparam int DLT_LAT_ROWS = 4;
   localparam int DLT_CODE_OFS = 1;
   localparam int DLT_MODE_OFS = 2;
   localparam int DLT_LAT_OFS  = 3;
   localparam int DLT_COL_STEP = 2;

   // transfer geometry
   localparam logic [5:0] DLT_ADDR3_BITS = 6'h18;
   localparam logic [5:0] DLT_ADDR4_BITS = 6'h20;
   localparam logic [3:0] DLT_BYTE_BITS  = 4'h8;
   localparam logic [3:0] DLT_OE_X1      = 4'h2;
   localparam logic [3:0] DLT_OE_X2      = 4'h3;
   localparam logic [3:0] DLT_OE_X4      = 4'hF;

   typedef enum logic [1:0] {
      DLT_K_FAST,
      DLT_K_DUAL,
      DLT_K_QUAD,
      DLT_K_QUERY
   } dlt_kind_type;

   typedef enum logic [2:0] {
      DLT_S_OPCODE,
      DLT_S_ADDR,
      DLT_S_MODE,
      DLT_S_LAT,
      DLT_S_DATA,
      DLT_S_IGNORE
   } dlt_state_type;

endpackage

// *** rtl/dlt_table.sv ***
// query table storage and per-code latency lookup
`timescale 1ns/1ps
module dlt_table
(
   dlt_tbl_if.tbl tbl
);

   logic [dlt_pkg::DLT_LAT_ROWS-1:0] row_hit;
   logic [7:0]                       row_mode [dlt_pkg::DLT_LAT_ROWS];
   logic [7:0]                       row_lat  [dlt_pkg::DLT_LAT_ROWS];
   int                               col;

   // query kind has no column; fold it onto the first to stay in range
   assign col = (tbl.kind == dlt_pkg::DLT_K_QUERY) ? 0 :
                int'(tbl.kind) * dlt_pkg::DLT_COL_STEP;

   // each row is matched by the latency code it stores
   genvar gi;
   generate
      for (gi = 0; gi < dlt_pkg::DLT_LAT_ROWS; gi++)
      begin : g_row
         localparam int BASE = dlt_pkg::DLT_ROW_BASE +
                               gi * int'(dlt_pkg::DLT_ROW_LEN);
         assign row_hit[gi]  =
            dlt_pkg::DLT_DDR_ROM[BASE + dlt_pkg::DLT_CODE_OFS][1:0] ==
            tbl.code;
         assign row_mode[gi] =
            dlt_pkg::DLT_DDR_ROM[BASE + dlt_pkg::DLT_MODE_OFS + col];
         assign row_lat[gi]  =
            dlt_pkg::DLT_DDR_ROM[BASE + dlt_pkg::DLT_LAT_OFS + col];
      end
   endgenerate

   // pick the row of the configured code; no hit reads as unsupported
   always_comb
   begin
      tbl.mode_cyc = dlt_pkg::DLT_NOT_SUPP;
      tbl.lat_cyc  = dlt_pkg::DLT_NOT_SUPP;
      for (int i = 0; i < dlt_pkg::DLT_LAT_ROWS; i++)
      begin
         if (row_hit[i])
         begin
            tbl.mode_cyc = row_mode[i];
            tbl.lat_cyc  = row_lat[i];
         end
      end
   end

   // byte read of the query image; holes read as all ones
   always_comb
   begin
      tbl.data = dlt_pkg::DLT_NOT_SUPP;
      if (int'(tbl.addr) < dlt_pkg::DLT_DDR_SIZE)
      begin
         tbl.data = dlt_pkg::DLT_DDR_ROM[int'(tbl.addr)];
      end
      else if (int'(tbl.addr) >= dlt_pkg::DLT_SDR_BASE &&
               int'(tbl.addr) < dlt_pkg::DLT_SDR_BASE +
                                dlt_pkg::DLT_SDR_SIZE)
      begin
         tbl.data = dlt_pkg::DLT_SDR_ROM[int'(tbl.addr) -
                                         dlt_pkg::DLT_SDR_BASE];
      end
   end

endmodule // dlt_table

// *** rtl/dlt_tbl_if.sv ***
// interface between the read sequencer and the query table
`timescale 1ns/1ps
interface dlt_tbl_if;
   logic [7:0]            addr;
   logic [7:0]            data;
   logic [1:0]            code;
   dlt_pkg::dlt_kind_type kind;
   logic [7:0]            mode_cyc;
   logic [7:0]            lat_cyc;

   modport tbl
   (
      input  addr,
      input  code,
      input  kind,
      output data,
      output mode_cyc,
      output lat_cyc
   );

   modport seq
   (
      output addr,
      output code,
      output kind,
      input  data,
      input  mode_cyc,
      input  lat_cyc
   );
endinterface

// *** rtl/dlt_top.sv ***
// serial read sequencer with ddr latency query table
`timescale 1ns/1ps

// Functional notes
// RL1: byte 00h returns parameter id 9Ah
// RL2: byte 01h gives following byte count 2Ah
// RL3: header row starts with ascii F, C
// RL4: fast ddr read opcodes 0Dh and 0Eh
// RL5: dual io ddr read opcodes BDh, BEh
// RL6: quad io ddr read opcodes EDh, EEh
// RL7: code 11b: latency four, four, three
// RL8: code 00b: latency five, six, six
// RL9: quad ddr one mode cycle, others none
// RL10: fastest sdr row multi-line reads unsupported
// RL11: all-ones entry means command not supported
// RL12: code 01b: latency six, seven, seven
// RL13: code 10b: latency seven, eight, eight
// RL14: dummy count follows the configured latency code
module dlt_top
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        sck,
   input  wire logic        cs_n,
   input  wire logic [3:0]  io_in,
   output logic      [3:0]  io_out,
   output logic      [3:0]  io_oe,
   input  wire logic [1:0]  latency_code,
   output logic      [31:0] mem_addr,
   input  wire logic [7:0]  mem_rd_data,
   output logic             mem_rd
);

   logic                   rst_s1_reg;
   logic                   rst_n;
   logic                   sck_s1_reg;
   logic                   sck_s2_reg;
   logic                   sck_s3_reg;
   logic                   cs_s1_reg;
   logic                   cs_s2_reg;
   logic [3:0]             io_s1_reg;
   logic [3:0]             io_s2_reg;
   logic                   rise;
   logic                   fall;
   logic                   active;
   dlt_pkg::dlt_state_type state_reg;
   dlt_pkg::dlt_kind_type  kind_reg;
   dlt_pkg::dlt_kind_type  dec_kind;
   logic                   ddr_reg;
   logic                   dec_ddr;
   logic                   dec_known;
   logic [5:0]             abits_reg;
   logic [5:0]             dec_abits;
   logic [5:0]             cnt_reg;
   logic [5:0]             cnt_next;
   logic [7:0]             op_reg;
   logic [7:0]             op_next;
   logic [31:0]            addr_reg;
   logic [8:0]             mode_cnt_reg;
   logic [7:0]             lat_cnt_reg;
   logic [7:0]             sh_reg;
   logic [3:0]             left_reg;
   logic [3:0]             io_out_reg;
   logic [3:0]             io_oe_reg;
   logic                   mem_rd_reg;
   logic [2:0]             lane_w;
   logic [3:0]             oe_mask;
   logic                   addr_edge;
   logic                   addr_done;
   logic                   step;
   logic                   drive_now;
   logic [7:0]             src_byte;
   logic [7:0]             out_byte;
   logic [3:0]             chunk;

   dlt_tbl_if tbl_bus ();

   dlt_table u_table
   (
      .tbl (tbl_bus.tbl)
   );

   // table is addressed by the low query address byte
   assign tbl_bus.addr = addr_reg[7:0];
   assign tbl_bus.code = latency_code;
   assign tbl_bus.kind = kind_reg;

   // reset release through two flops
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_s1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_n      <= rst_s1_reg;
      end
   end

   // pin synchronisers; third sck flop only serves edge detection
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sck_s1_reg <= 1'b0;
         sck_s2_reg <= 1'b0;
         sck_s3_reg <= 1'b0;
         cs_s1_reg  <= 1'b1;
         cs_s2_reg  <= 1'b1;
         io_s1_reg  <= 4'h0;
         io_s2_reg  <= 4'h0;
      end
      else
      begin
         sck_s1_reg <= sck;
         sck_s2_reg <= sck_s1_reg;
         sck_s3_reg <= sck_s2_reg;
         cs_s1_reg  <= cs_n;
         cs_s2_reg  <= cs_s1_reg;
         io_s1_reg  <= io_in;
         io_s2_reg  <= io_s1_reg;
      end
   end

   // link edges as seen in the clk domain, about two cycles late
   assign rise   = sck_s2_reg & ~sck_s3_reg;
   assign fall   = ~sck_s2_reg & sck_s3_reg;
   assign active = ~cs_s2_reg;

   // lines used per edge and lines driven for data
   always_comb
   begin
      unique case (kind_reg)
         dlt_pkg::DLT_K_DUAL:
         begin
            lane_w  = 3'h2;
            oe_mask = dlt_pkg::DLT_OE_X2;
         end
         dlt_pkg::DLT_K_QUAD:
         begin
            lane_w  = 3'h4;
            oe_mask = dlt_pkg::DLT_OE_X4;
         end
         dlt_pkg::DLT_K_FAST, dlt_pkg::DLT_K_QUERY:
         begin
            lane_w  = 3'h1;
            oe_mask = dlt_pkg::DLT_OE_X1;
         end
      endcase
   end

   assign op_next = {op_reg[6:0], io_s2_reg[0]};

   // opcode decode
   always_comb
   begin
      dec_kind  = dlt_pkg::DLT_K_QUERY;
      dec_ddr   = 1'b1;
      dec_abits = dlt_pkg::DLT_ADDR3_BITS;
      dec_known = 1'b1;
      unique case (op_next)
         dlt_pkg::DLT_OP_QUERY:
            dec_ddr = 1'b0;
         // RL4 fast ddr decode
         dlt_pkg::DLT_OP_FAST3:
            dec_kind = dlt_pkg::DLT_K_FAST;
         dlt_pkg::DLT_OP_FAST4:
         begin
            dec_kind  = dlt_pkg::DLT_K_FAST;
            dec_abits = dlt_pkg::DLT_ADDR4_BITS;
         end
         // RL5 dual ddr decode
         dlt_pkg::DLT_OP_DUAL3:
            dec_kind = dlt_pkg::DLT_K_DUAL;
         dlt_pkg::DLT_OP_DUAL4:
         begin
            dec_kind  = dlt_pkg::DLT_K_DUAL;
            dec_abits = dlt_pkg::DLT_ADDR4_BITS;
         end
         // RL6 quad ddr decode
         dlt_pkg::DLT_OP_QUAD3:
            dec_kind = dlt_pkg::DLT_K_QUAD;
         dlt_pkg::DLT_OP_QUAD4:
         begin
            dec_kind  = dlt_pkg::DLT_K_QUAD;
            dec_abits = dlt_pkg::DLT_ADDR4_BITS;
         end
         default:
            dec_known = 1'b0;
      endcase
   end

   // ddr address starts on a rising edge, then takes both edges
   assign addr_edge = rise | (fall & ddr_reg & (cnt_reg != 6'h00));
   assign cnt_next  = 6'(cnt_reg + 6'(lane_w));
   assign addr_done = addr_edge & (cnt_next >= abits_reg);
   assign step      = ddr_reg ? (rise | fall) : fall;
   assign drive_now = (state_reg == dlt_pkg::DLT_S_DATA & step) |
                      (state_reg == dlt_pkg::DLT_S_LAT & fall &
                       lat_cnt_reg == 8'h01);

   // command sequencer
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg    <= dlt_pkg::DLT_S_OPCODE;
         kind_reg     <= dlt_pkg::DLT_K_QUERY;
         ddr_reg      <= 1'b0;
         abits_reg    <= dlt_pkg::DLT_ADDR3_BITS;
         cnt_reg      <= 6'h00;
         op_reg       <= 8'h00;
         mode_cnt_reg <= 9'h000;
         lat_cnt_reg  <= 8'h00;
      end
      else if (!active)
      begin
         state_reg <= dlt_pkg::DLT_S_OPCODE;
         ddr_reg   <= 1'b0;
         cnt_reg   <= 6'h00;
      end
      else
      begin
         unique case (state_reg)
            dlt_pkg::DLT_S_OPCODE:
               if (rise)
               begin
                  op_reg <= op_next;
                  if (cnt_reg == 6'(dlt_pkg::DLT_BYTE_BITS - 4'h1))
                  begin
                     cnt_reg   <= 6'h00;
                     kind_reg  <= dec_kind;
                     ddr_reg   <= dec_ddr;
                     abits_reg <= dec_abits;
                     state_reg <= dec_known ? dlt_pkg::DLT_S_ADDR :
                                              dlt_pkg::DLT_S_IGNORE;
                  end
                  else
                     cnt_reg <= 6'(cnt_reg + 6'h01);
               end
            dlt_pkg::DLT_S_ADDR:
               if (addr_done)
               begin
                  cnt_reg      <= 6'h00;
                  // RL14 latency from code
                  lat_cnt_reg  <= tbl_bus.lat_cyc;
                  // RL9 mode cycle count
                  mode_cnt_reg <= {tbl_bus.mode_cyc, 1'b0};
                  if (kind_reg == dlt_pkg::DLT_K_QUERY)
                     state_reg <= dlt_pkg::DLT_S_DATA;
                  // RL11 unsupported entry refused
                  else if (tbl_bus.lat_cyc == dlt_pkg::DLT_NOT_SUPP)
                     state_reg <= dlt_pkg::DLT_S_IGNORE;
                  else if (tbl_bus.mode_cyc != 8'h00)
                     state_reg <= dlt_pkg::DLT_S_MODE;
                  else if (tbl_bus.lat_cyc == 8'h00)
                     state_reg <= dlt_pkg::DLT_S_DATA;
                  else
                     state_reg <= dlt_pkg::DLT_S_LAT;
               end
               else if (addr_edge)
                  cnt_reg <= cnt_next;
            // RL9 mode bits skipped
            dlt_pkg::DLT_S_MODE:
               if (rise | fall)
               begin
                  mode_cnt_reg <= 9'(mode_cnt_reg - 9'h001);
                  if (mode_cnt_reg == 9'h001)
                     state_reg <= dlt_pkg::DLT_S_LAT;
               end
            // RL7 RL8 RL12 RL13 dummy countdown
            dlt_pkg::DLT_S_LAT:
               if (fall)
               begin
                  lat_cnt_reg <= 8'(lat_cnt_reg - 8'h01);
                  if (lat_cnt_reg == 8'h01)
                     state_reg <= dlt_pkg::DLT_S_DATA;
               end
            dlt_pkg::DLT_S_DATA, dlt_pkg::DLT_S_IGNORE:
               state_reg <= state_reg;
         endcase
      end
   end

   // address shift-in and post-increment per byte sent
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         addr_reg <= 32'h0000_0000;
      else if (active && state_reg == dlt_pkg::DLT_S_OPCODE && rise)
         addr_reg <= 32'h0000_0000;
      else if (state_reg == dlt_pkg::DLT_S_ADDR && addr_edge)
      begin
         unique case (lane_w)
            3'h2:    addr_reg <= {addr_reg[29:0], io_s2_reg[1:0]};
            3'h4:    addr_reg <= {addr_reg[27:0], io_s2_reg[3:0]};
            default: addr_reg <= {addr_reg[30:0], io_s2_reg[0]};
         endcase
      end
      else if (drive_now && left_reg == 4'h0)
         addr_reg <= 32'(addr_reg + 32'h0000_0001);
   end

   // RL1 RL2 query bytes
   // RL3 header row bytes
   // RL10 sdr tail reads
   assign src_byte = (kind_reg != dlt_pkg::DLT_K_QUERY) ? mem_rd_data :
                     (addr_reg[31:8] == 24'h00_0000) ? tbl_bus.data :
                     dlt_pkg::DLT_NOT_SUPP;
   assign out_byte = (left_reg == 4'h0) ? src_byte : sh_reg;

   // top bits of the byte, placed on the lines in use
   always_comb
   begin
      unique case (lane_w)
         3'h2:    chunk = {2'h0, out_byte[7:6]};
         3'h4:    chunk = out_byte[7:4];
         default: chunk = {2'h0, out_byte[7], 1'h0};
      endcase
   end

   // data shifter; io_out stays put between link edges, io_oe clears on deselect
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sh_reg     <= 8'h00;
         left_reg   <= 4'h0;
         io_out_reg <= 4'h0;
         io_oe_reg  <= 4'h0;
         mem_rd_reg <= 1'b0;
      end
      else if (!active)
      begin
         left_reg   <= 4'h0;
         io_oe_reg  <= 4'h0;
         mem_rd_reg <= 1'b0;
      end
      else
      begin
         mem_rd_reg <= drive_now & (left_reg == 4'h0) &
                       (kind_reg != dlt_pkg::DLT_K_QUERY);
         if (drive_now)
         begin
            sh_reg     <= out_byte << lane_w;
            io_out_reg <= chunk;
            io_oe_reg  <= oe_mask;
            // a new byte is taken once the last chunk has gone
            if (left_reg == 4'h0)
               left_reg <= 4'(dlt_pkg::DLT_BYTE_BITS - 4'(lane_w));
            else
               left_reg <= 4'(left_reg - 4'(lane_w));
         end
      end
   end

   assign io_out   = io_out_reg;
   assign io_oe    = io_oe_reg;
   assign mem_addr = addr_reg;
   assign mem_rd   = mem_rd_reg;

endmodule // dlt_top
